/* pas_pkg.sv */
/*
  Package for the performance-overflow and alarm-select block: register
  offsets, field positions, reset values and widths.
  Assumes an AHB-Lite slave with 32-bit data, one register per word.
*/
package pas_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_STATUS_A   = 8'h20;
  localparam logic [7:0] IDX_STATUS_B   = 8'h21;
  localparam logic [7:0] IDX_MASK_A     = 8'h22;
  localparam logic [7:0] IDX_MASK_B     = 8'h23;
  localparam logic [7:0] IDX_SELECT_A   = 8'h25;
  localparam logic [7:0] IDX_SELECT_B   = 8'h26;
  localparam logic [7:0] IDX_CAUSE      = 8'h06;

  // Widths of the implemented fields
  localparam int GROUP_A_BITS = 6;
  localparam int GROUP_B_BITS = 4;
  localparam int SELECT_B_BITS = 5;

  // Field positions
  localparam int SELECT_A_CMD_BIT   = 7;
  localparam int SELECT_A_SPARE_BIT = 6;
  localparam int CAUSE_PCO_BIT      = 0;

  // Reset values
  localparam logic [7:0] RESET_STATUS = 8'h00;
  localparam logic [7:0] RESET_MASK   = 8'h00;
  localparam logic [7:0] RESET_SELECT = 8'h00;

  // Byte address of the register index
  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

endpackage : pas_pkg

/* pas_top.sv */
/*
  Performance-overflow status/mask, interrupt cause and alarm-pin select.
  Assumes one AHB-Lite master, events synchronous to hclk, one-cycle
  overflow pulses from the counters and level alarm conditions.
*/
// Summary of operation
// - Status B bits 3..0: header error, FIFO full, idle, info cell overflow.
// - Status A bits 5..0: B1, B2, B3, line FEBE, path FEBE, justification.
// - Reading an overflow status register clears its flags, except those set again by an event in the same cycle.
// - Cause bit is one while any unmasked overflow flag is set.
// - Masked flags are still recorded but do not raise the cause bit.
// - Mask bit one passes its flag; masks reset to zero.
// - Mask A bits 5..0 follow the status A layout.
// - Mask B bits 3..0 follow the status B layout.
// - Unused upper status and mask bits read zero, ignore writes.
// - Selected detected alarm drives alarm pin high until the alarm condition clears.
// - Select A bits 5..0: LOS, OOF, LOF, LOP, OUT_OF_CELL_DELINEATION, LOSS_CELL_DELINEATION.
// - Select A bit 7 forwards the command alarm flag to the pin.
// - Select B bits 4..0: PLL unlock, line AIS, path AIS, line RDI, path RDI.
// - All select bits reset to zero.
module pas_top
(
  // Clock and reset
  input  wire logic                              hclk,
  input  wire logic                              hresetn,
  // AHB-Lite slave
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic                              hready,
  input  wire logic [31:0]                       hwdata,
  output logic      [31:0]                       hrdata,
  output logic                                   hreadyout,
  output logic                                   hresp,
  // Counter overflow pulses
  input  wire logic [pas_pkg::GROUP_A_BITS-1:0]  overflow_a,
  input  wire logic [pas_pkg::GROUP_B_BITS-1:0]  overflow_b,
  // Alarm conditions
  input  wire logic [5:0]                        alarm_a,
  input  wire logic [pas_pkg::SELECT_B_BITS-1:0] alarm_b,
  input  wire logic                              command_alarm_flag,
  // Outputs
  output logic                                   alarm_output_pin,
  output logic                                   perf_overflow_cause,
  output logic                                   irq
);
  import pas_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Bus address phase capture

  logic                     wr_pend;
  logic                     rd_now;
  logic [9:0]               addr_q;
  logic [GROUP_A_BITS-1:0]  status_a;
  logic [GROUP_B_BITS-1:0]  status_b;
  logic [GROUP_A_BITS-1:0]  mask_a;
  logic [GROUP_B_BITS-1:0]  mask_b;
  logic [7:0]               select_a;
  logic [SELECT_B_BITS-1:0] select_b;
  logic                     irq_mask;
  logic [7:0]               next_rdata;
  logic                     take;
  logic                     cause_now;
  logic                     rd_status_a;
  logic                     rd_status_b;
  logic                     wr_mask_a;
  logic                     wr_mask_b;
  logic                     wr_select_a;
  logic                     wr_select_b;
  logic                     wr_cause;

  assign take = hsel && hready && htrans[1];
  assign rd_now = take && !hwrite;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      addr_q  <= 10'h000;
    end
    else if (hready)
    begin
      wr_pend <= take && hwrite;
      addr_q  <= haddr[9:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, registered at the address phase

  always_comb
  begin
    next_rdata = 8'h00;
    case (haddr[9:0])
      byte_addr(IDX_STATUS_A): next_rdata = {2'b00, status_a};
      byte_addr(IDX_STATUS_B): next_rdata = {4'h0, status_b};
      byte_addr(IDX_MASK_A):   next_rdata = {2'b00, mask_a};
      byte_addr(IDX_MASK_B):   next_rdata = {4'h0, mask_b};
      byte_addr(IDX_SELECT_A): next_rdata = select_a;
      byte_addr(IDX_SELECT_B): next_rdata = {3'b000, select_b};
      byte_addr(IDX_CAUSE):    next_rdata = {6'h00, irq_mask, perf_overflow_cause};
      default:                 next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_now)
      hrdata <= {24'h000000, next_rdata};
  end

  // Zero wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout <= 1'b1;
    else
      hreadyout <= 1'b1;
  end

  // Always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Overflow status, clear on read with set priority

  assign rd_status_a = rd_now && (haddr[9:0] == byte_addr(IDX_STATUS_A));
  assign rd_status_b = rd_now && (haddr[9:0] == byte_addr(IDX_STATUS_B));

  // Group A flags
  pas_sticky_flags
  #(
    .WIDTH (GROUP_A_BITS)
  )
  u_status_a
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .event_in (overflow_a),
    .clear    (rd_status_a),
    .flags    (status_a)
  );

  // Group B flags
  pas_sticky_flags
  #(
    .WIDTH (GROUP_B_BITS)
  )
  u_status_b
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .event_in (overflow_b),
    .clear    (rd_status_b),
    .flags    (status_b)
  );

  //////////////////////////////////////////////////////////////////////////
  // Mask and select registers, written in the data phase

  assign wr_mask_a   = wr_pend && (addr_q == byte_addr(IDX_MASK_A));
  assign wr_mask_b   = wr_pend && (addr_q == byte_addr(IDX_MASK_B));
  assign wr_select_a = wr_pend && (addr_q == byte_addr(IDX_SELECT_A));
  assign wr_select_b = wr_pend && (addr_q == byte_addr(IDX_SELECT_B));
  assign wr_cause    = wr_pend && (addr_q == byte_addr(IDX_CAUSE));

  // Group A mask
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask_a <= RESET_MASK[GROUP_A_BITS-1:0];
    else if (wr_mask_a)
      mask_a <= hwdata[GROUP_A_BITS-1:0];
  end

  // Group B mask
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask_b <= RESET_MASK[GROUP_B_BITS-1:0];
    else if (wr_mask_b)
      mask_b <= hwdata[GROUP_B_BITS-1:0];
  end

  // Alarm select A, spare bit stored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      select_a <= RESET_SELECT;
    else if (wr_select_a)
      select_a <= hwdata[7:0];
  end

  // Alarm select B
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      select_b <= RESET_SELECT[SELECT_B_BITS-1:0];
    else if (wr_select_b)
      select_b <= hwdata[SELECT_B_BITS-1:0];
  end

  // Interrupt enable in the cause register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_mask <= 1'b0;
    else if (wr_cause)
      irq_mask <= hwdata[1];
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt cause and alarm pin

  assign cause_now = |(status_a & mask_a) || |(status_b & mask_b);

  // Cause bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      perf_overflow_cause <= 1'b0;
    else
      perf_overflow_cause <= cause_now;
  end

  // Interrupt line
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= cause_now && irq_mask;
  end

  // Alarm pin

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      alarm_output_pin <= 1'b0;
    else
      alarm_output_pin <= |(alarm_a & select_a[5:0])
                        || |(alarm_b & select_b)
                        || (command_alarm_flag && select_a[SELECT_A_CMD_BIT]);
  end

endmodule // pas_top

////////////////////////////////////////////////////////////////////////////
// Clear-on-read flag bank; a new event wins over the clear

module pas_sticky_flags
#(
  parameter int WIDTH = pas_pkg::GROUP_B_BITS
)
(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Overflow pulses and read clear
  input  wire logic [WIDTH-1:0] event_in,
  input  wire logic             clear,
  // Recorded flags
  output logic      [WIDTH-1:0] flags
);
  import pas_pkg::*;

  logic [WIDTH-1:0] next_flags;

  always_comb
  begin
    next_flags = flags | event_in;
    if (clear)
      next_flags = event_in;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags <= RESET_STATUS[WIDTH-1:0];
    else
      flags <= next_flags;
  end

endmodule // pas_sticky_flags

/* pas_props.sv */
/* Port checker for pas_top.
   Assumes a bind onto pas_top and hready tied to hreadyout. */
module pas_props
  import pas_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [5:0]  alarm_a,
  input wire logic [4:0]  alarm_b,
  input wire logic        command_alarm_flag,
  input wire logic        alarm_output_pin,
  input wire logic        perf_overflow_cause,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_start; $rose(hresetn); endsequence
  sequence s_pin_low2; !alarm_output_pin [*2]; endsequence
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_upper; hrdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("hrdata upper bits set");
  property p_irq; irq |-> perf_overflow_cause; endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_quiet; !(|alarm_a || |alarm_b || command_alarm_flag) |=> !alarm_output_pin; endproperty
  a_quiet: assert property (p_quiet) else $error("alarm pin without alarm");
  property p_hold; !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("hrdata changed without read");
  property p_pin_rst; s_start |-> s_pin_low2; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("alarm pin after reset");
  property p_cause_rst; s_start |-> !perf_overflow_cause ##1 !perf_overflow_cause; endproperty
  a_cause_rst: assert property (p_cause_rst) else $error("cause after reset");
endmodule // pas_props

/* pas_host.sv */
/* Host bus master model: single AHB-Lite word transfers.
   Assumes one zero-or-more wait slave whose hreadyout is hready. */
module pas_host
  import pas_pkg::*;
(
  // Answer
  input  wire logic        hclk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  // Request
  output logic             hsel = 1'b0,
  output logic [31:0]      haddr = 32'h0,
  output logic [1:0]       htrans = 2'b00,
  output logic             hwrite = 1'b0,
  output logic [2:0]       hsize = 3'b010,
  output logic [31:0]      hwdata = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
endmodule // pas_host

/* testbench.sv */
/* Self-checking bench for pas_top.
   Assumes pas_host as bus master and pas_props bound to the top. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pas_pkg::*;
  logic hclk = 0, hresetn = 0, hsel, hwrite, hreadyout, hresp, command_alarm_flag = 0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [5:0] overflow_a = 0, alarm_a = 0;
  logic [3:0] overflow_b = 0;
  logic [4:0] alarm_b = 0;
  logic [11:0] v;
  logic alarm_output_pin, perf_overflow_cause, irq;
  int err_count = 0, n_tests = 0, cyc = 0;
  pas_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .overflow_a, .overflow_b, .alarm_a, .alarm_b,
    .command_alarm_flag, .alarm_output_pin, .perf_overflow_cause, .irq);
  pas_host host (.hclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
  always #50 hclk = ~hclk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] e);
    host.xfer(1'b0, idx, 32'h0, d);
    chk(nm, e, d);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic pulse(input logic [5:0] a, input logic [3:0] b);
    @(posedge hclk);
    overflow_a <= a;
    overflow_b <= b;
    @(posedge hclk);
    overflow_a <= 6'h0;
    overflow_b <= 4'h0;
    tick(1);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] idx_list [8];
    idx_list = '{IDX_STATUS_A, IDX_STATUS_B, IDX_MASK_A, IDX_MASK_B, IDX_SELECT_A,
                 IDX_SELECT_B, IDX_CAUSE, 8'h3f};
    chk("hreadyout", 32'h1, hreadyout);
    chk("hresp", 32'h0, hresp);
    chk("pin at reset", 32'h0, alarm_output_pin);
    chk("cause at reset", 32'h0, perf_overflow_cause);
    foreach (idx_list[i])
      rdc("reset value", idx_list[i], 32'h0);
  endtask
  task automatic t_overflow;
    host.xfer(1'b1, IDX_MASK_A, 32'hff, d);
    host.xfer(1'b1, IDX_MASK_B, 32'h08, d);
    rdc("mask a", IDX_MASK_A, 32'h3f);
    rdc("mask b", IDX_MASK_B, 32'h08);
    pulse(6'h3f, 4'h7);
    chk("cause", 32'h1, perf_overflow_cause);
    rdc("status a", IDX_STATUS_A, 32'h3f);
    rdc("status a again", IDX_STATUS_A, 32'h0);
    tick(1);
    chk("cause masked", 32'h0, perf_overflow_cause);
    rdc("status b masked", IDX_STATUS_B, 32'h07);
    host.xfer(1'b1, IDX_CAUSE, 32'h2, d);
    pulse(6'h0, 4'h8);
    chk("irq", 32'h1, irq);
    rdc("status b", IDX_STATUS_B, 32'h08);
    tick(1);
    chk("irq cleared", 32'h0, irq);
    fork
      host.xfer(1'b0, IDX_STATUS_B, 32'h0, d);
      begin
        @(posedge hclk);
        overflow_b <= 4'h4;
        @(posedge hclk);
        overflow_b <= 4'h0;
      end
    join
    chk("status b race first", 32'h0, d);
    rdc("status b race", IDX_STATUS_B, 32'h04);
  endtask
  task automatic t_alarm;
    for (int i = 0; i < 12; i++)
    begin
      v = 12'h1 << i;
      host.xfer(1'b1, IDX_SELECT_A, {24'h0, v[11], 1'b0, v[10:5]}, d);
      host.xfer(1'b1, IDX_SELECT_B, {27'h0, v[4:0]}, d);
      @(posedge hclk);
      {command_alarm_flag, alarm_a, alarm_b} <= ~v;
      tick(2);
      chk("pin unselected", 32'h0, alarm_output_pin);
      @(posedge hclk);
      {command_alarm_flag, alarm_a, alarm_b} <= v;
      tick(2);
      chk("pin selected", 32'h1, alarm_output_pin);
    end
    rdc("select a", IDX_SELECT_A, 32'h80);
  endtask
  task automatic t_midreset;
    @(posedge hclk);
    hresetn <= 1'b0;
    tick(2);
    chk("pin in reset", 32'h0, alarm_output_pin);
    @(posedge hclk);
    hresetn <= 1'b1;
    rdc("select a after reset", IDX_SELECT_A, 32'h0);
    rdc("select b after reset", IDX_SELECT_B, 32'h0);
    rdc("mask a after reset", IDX_MASK_A, 32'h0);
    tick(1);
    chk("pin after reset", 32'h0, alarm_output_pin);
  endtask
  ////////////////////////////////////////
  task automatic print_verdict;
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_overflow();
    t_alarm();
    t_midreset();
    print_verdict();
  end
endmodule // testbench
bind pas_top pas_props u_props (.hclk, .hresetn, .hsel, .hready, .htrans, .hwrite, .hrdata,
  .hreadyout, .hresp, .alarm_a, .alarm_b, .command_alarm_flag, .alarm_output_pin,
  .perf_overflow_cause, .irq);
